// >>> sim/pin_source.sv
// far-side source of the channel's capture input pins
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    input wire logic pclk,
    output logic pin_a,
    output logic pin_b
);
    // both pins are pulled to a known level at time zero
    initial
    begin
        pin_a = 1'b0;
        pin_b = 1'b1;
    end
    // levels change just after an edge, never on it
    task automatic drive(input logic a, input logic b);
        @(posedge pclk);
        pin_a <= a;
        pin_b <= b;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_timer_capture_compare_ctrl_status.sv
// testbench of the capture/compare control and status block
`timescale 1ns/1ps
`default_nettype none
module tb_timer_capture_compare_ctrl_status;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, count_tick = 1'b0;
    logic count_down = 1'b0, dma_ack_a = 1'b0, pready, pslverr, slv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] timer_count = 16'h0000;
    logic chan_pin_a_in, chan_pin_b_in, chan_pin_a, chan_pin_b;
    logic match_a_irq, match_b_irq, wrap_irq;
    int err_total = 0, total_checks = 0;
    always #10 pclk = ~pclk;
    // channel 2 so that the toggle code must come out as drive 1
    timer_capture_compare_ctrl_status #(.CHANNEL(2)) uut (.*);
    pin_source far (.pclk(pclk), .pin_a(chan_pin_a_in), .pin_b(chan_pin_b_in));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_total++;
            report_and_stop();
        end
        else
        begin
            rd = prdata;
            slv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // one counter step shown at value v, then room for flag and pin to land
    task automatic tick(input logic [15:0] v, input logic dn);
        @(posedge pclk);
        timer_count <= v;
        count_down <= dn;
        count_tick <= 1'b1;
        @(posedge pclk);
        count_tick <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic t_reset;
        apb(0, 12'h000, 0);
        chk("fsel", rd, 32'h88);
        apb(0, 12'h004, 0);
        chk("flags", rd, 32'hf8);
        apb(0, 12'h008, 0);
        chk("ien", rd, 32'hf8);
        chk("pins", {chan_pin_b, chan_pin_a}, 2'b00);
        apb(0, 12'h020, 0);
        chk("slverr", {slv, rd}, {1'b1, 32'h0});
        apb(1, 12'h014, 32'h1);
        apb(0, 12'h014, 32'h0);
        chk("mode", rd, 32'h1);
        apb(1, 12'h014, 32'h0);
    endtask
    task automatic t_compare;
        apb(1, 12'h00c, 5);
        apb(1, 12'h010, 5);
        apb(1, 12'h000, 32'h3a);
        apb(1, 12'h008, 3);
        tick(5, 0);
        chk("pins", {chan_pin_b, chan_pin_a}, 2'b11);
        chk("irqs", {match_b_irq, match_a_irq}, 2'b11);
        tick(5, 0);
        chk("no toggle", chan_pin_b, 1'b1);
        apb(1, 12'h000, 32'h09);
        tick(5, 0);
        chk("pins", {chan_pin_b, chan_pin_a}, 2'b10);
        apb(0, 12'h018, 32'h0);
        chk("status", rd, 32'h2);
    endtask
    task automatic t_clear;
        apb(1, 12'h004, 32'hf8);
        apb(0, 12'h004, 0);
        chk("unread", rd, 32'hfb);
        apb(1, 12'h004, 32'hfe);
        apb(0, 12'h004, 0);
        chk("cleared", rd, 32'hfa);
        tick(5, 0);
        chk("irq a", match_a_irq, 1'b1);
        @(posedge pclk);
        dma_ack_a <= 1'b1;
        @(posedge pclk);
        dma_ack_a <= 1'b0;
        apb(0, 12'h004, 0);
        chk("dma clear", rd, 32'hfa);
    endtask
    task automatic t_wrap;
        apb(1, 12'h008, 4);
        tick(16'hffff, 0);
        chk("wrap up", wrap_irq, 1'b1);
        apb(0, 12'h004, 0);
        apb(1, 12'h004, 32'hfb);
        tick(0, 0);
        chk("no wrap", wrap_irq, 1'b0);
        tick(0, 1);
        chk("wrap down", wrap_irq, 1'b1);
    endtask
    task automatic t_capture;
        apb(1, 12'h008, 3);
        apb(1, 12'h000, 32'h5c);
        apb(0, 12'h004, 0);
        apb(1, 12'h004, 32'hf8);
        tick(16'h1234, 0);
        far.drive(1, 1);
        repeat (6) @(posedge pclk);
        chk("irqs", {match_b_irq, match_a_irq}, 2'b01);
        apb(0, 12'h00c, 0);
        chk("cap a", rd, 32'h1234);
        tick(16'h0042, 0);
        far.drive(1, 0);
        repeat (6) @(posedge pclk);
        apb(0, 12'h010, 0);
        chk("cap b", {match_b_irq, rd}, {1'b1, 32'h42});
        apb(1, 12'h000, 32'h7e);
        tick(16'h0077, 0);
        far.drive(0, 1);
        repeat (6) @(posedge pclk);
        apb(0, 12'h00c, 0);
        chk("both a", rd, 32'h77);
        apb(0, 12'h010, 0);
        chk("code 7 b", rd, 32'h42);
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_compare();
        t_clear();
        t_wrap();
        t_capture();
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> sim/tcc_monitor.sv
// port checker for the capture/compare control block
`timescale 1ns/1ps
`default_nettype none
module tcc_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic count_tick,
    input wire logic dma_ack_a,
    input wire logic chan_pin_a,
    input wire logic chan_pin_b,
    input wire logic match_a_irq,
    input wire logic match_b_irq,
    input wire logic wrap_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic rd;
    // completed bus accesses
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    property p_fsel_one; rd && paddr == 12'h000 |-> prdata[3]; endproperty
    a_fsel_one: assert property (p_fsel_one) else $error("fsel bit 3 low");
    property p_flag_ones; rd && paddr == 12'h004 |-> prdata[7:3] == 5'h1f; endproperty
    a_flag_ones: assert property (p_flag_ones) else $error("flag ones lost");
    property p_rst_pins; $rose(presetn) |-> !chan_pin_a && !chan_pin_b; endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pin high at reset");
    property p_a_fall; $fell(match_a_irq) |-> $past(wr) || $past(dma_ack_a); endproperty
    a_a_fall: assert property (p_a_fall) else $error("a irq fell alone");
    property p_b_fall; $fell(match_b_irq) |-> $past(wr); endproperty
    a_b_fall: assert property (p_b_fall) else $error("b irq fell alone");
    property p_w_fall; $fell(wrap_irq) |-> $past(wr); endproperty
    a_w_fall: assert property (p_w_fall) else $error("wrap irq fell alone");
    // a tick may land one or two edges later, so both depths count as cause
    property p_w_rise; $rose(wrap_irq) |-> $past(count_tick) || $past(count_tick, 2) || $past(wr);
    endproperty
    a_w_rise: assert property (p_w_rise) else $error("wrap irq rose alone");
    property p_pa_hold;
        $changed(chan_pin_a) |-> $past(count_tick) || $past(count_tick, 2) || $past(wr);
    endproperty
    a_pa_hold: assert property (p_pa_hold) else $error("pin a moved alone");
    c_fsel: cover property (wr && paddr == 12'h000);
    c_cap: cover property ($rose(match_a_irq));
    c_pin: cover property ($rose(chan_pin_b));
endmodule
bind timer_capture_compare_ctrl_status tcc_monitor mon (.*);
`default_nettype wire

// >>> verilog/tcc_consts.svh
// register offsets, field positions, reset values for the capture/compare control block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_OFF_FSEL 12'h000
`define TCC_OFF_FLAGS 12'h004
`define TCC_OFF_IEN 12'h008
`define TCC_OFF_GRA 12'h00c
`define TCC_OFF_GRB 12'h010
`define TCC_OFF_MODE 12'h014
`define TCC_OFF_STAT 12'h018
`define TCC_FSEL_RESET 8'h88
`define TCC_FLAGS_RESET 8'hf8
`define TCC_IEN_RESET 8'hf8
`define TCC_FSEL_ONE_MASK 8'h08
`define TCC_FLAGS_ONE_MASK 8'h78
`define TCC_BIT_WRAP 2
`define TCC_BIT_MB 1
`define TCC_BIT_MA 0
`define TCC_BFIELD_LSB 4
`define TCC_AFIELD_LSB 0
`define TCC_MODE_PWM_BIT 0
`define TCC_NUM_DMA_CHANS 4
`define TCC_NO_TOGGLE_CHAN 2
`endif

// >>> verilog/tcc_pkg.sv
// types for the capture/compare control block
package tcc_pkg;
    typedef enum logic [2:0] {
        FN_CMP_NONE = 3'h0,
        FN_CMP_LOW = 3'h1,
        FN_CMP_HIGH = 3'h2,
        FN_CMP_TOGGLE = 3'h3,
        FN_CAP_RISE = 3'h4,
        FN_CAP_FALL = 3'h5,
        FN_CAP_BOTH = 3'h6,
        FN_CAP_NONE = 3'h7
    } func_code_t;
endpackage

// >>> verilog/timer_capture_compare_ctrl_status.sv
// capture/compare control and status logic of one timer channel with an apb slave
// How it works
// - b field 000-011 makes reg b compare: none, drive 0, drive 1, toggle
// - b field 100/101/110 captures counter into reg b on rise, fall, both
// - a field 000-011 makes reg a compare: none, drive 0, drive 1, toggle
// - a field 100/101/110 captures counter into reg a on rise, fall, both
// - compare pins drive 0 after reset until first match
// - channel 2 turns toggle into drive 1
// - function select ignored for channels 3/4 in the pwm combination modes
// - function select resets to 0x88, bit 3 reads 1, bit 7 writable
// - flags register resets to 0xf8, bits 7-3 read 1
// - wrap flag sets on counter rollover or rollunder
// - rollunder only happens while counting down
// - flag clears by writing 0 after reading it as 1; writing 1 does nothing
// - b flag sets on b compare equality or b capture
// - a flag sets on a compare equality or a capture
// - dma acknowledge clears a flag, channels 0-3 only
// - interrupt asserted while a flag and its enable are both set
// - enable bits 2,1,0 for wrap, b, a; reset disabled
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
module timer_capture_compare_ctrl_status #(
    parameter int CHANNEL = 0,
    parameter int CW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CW-1:0] timer_count,
    input wire logic count_tick,
    input wire logic count_down,
    input wire logic chan_pin_a_in,
    input wire logic chan_pin_b_in,
    output logic chan_pin_a,
    output logic chan_pin_b,
    input wire logic dma_ack_a,
    output logic match_a_irq,
    output logic match_b_irq,
    output logic wrap_irq
);
    logic [7:0] fsel_q;
    logic [2:0] flags_q;
    logic [2:0] flags_seen_q;
    logic [2:0] ien_q;
    logic [CW-1:0] general_reg_a_q;
    logic [CW-1:0] general_reg_b_q;
    logic pwm_combo_q;
    logic [1:0] sync_a_q;
    logic [1:0] sync_b_q;
    logic last_a_q;
    logic last_b_q;
    logic chan_pin_a_q;
    logic chan_pin_b_q;
    logic [31:0] prdata_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    tcc_pkg::func_code_t code_a;
    tcc_pkg::func_code_t code_b;
    logic cap_a;
    logic cap_b;
    logic cmp_a;
    logic cmp_b;
    logic wrap_evt;
    logic [2:0] set_evt;
    logic [2:0] clr_evt;

    // register map, one aligned 32-bit word per register, narrow data in the low bits:
    // 0x000 function select, b field in 6:4, a field in 2:0, bit 3 forced to 1
    // 0x004 event flags, wrap in bit 2, b match in bit 1, a match in bit 0
    // 0x008 interrupt enables, same bit order as the flags
    // 0x00c general register a, 0x010 general register b
    // 0x014 mode, bit 0 selects the pwm combination on channels 3 and 4
    // 0x018 status, live levels of the two compare pins
    // any other offset answers with pslverr, a write there is dropped, a read gives 0
    //
    // the counter itself lives outside this block; it hands over its value,
    // a one-cycle tick when it advances and a level telling the count direction.
    // the value shown with the tick is the value before the advance, so a
    // rollover is seen while the counter still shows all ones going up,
    // or all zeros going down.
    //
    // limitations a user should know:
    // - a compare only fires on a tick, so a counter that stalls on a match
    //   value does not raise the flag again every cycle
    // - a capture is seen about three edges after the pin moves, because of
    //   the two-flop synchroniser and the edge detector behind it
    // - pulses on the pins shorter than one clock period may be lost
    // - a capture and a software write to the same general register in one
    //   cycle: the capture wins, since losing a hardware event is worse
    // - the pwm combination only forces plain compare with no pin action;
    //   the waveform generation itself is not part of this block
    //
    // hazard: flags are set by hardware and cleared by software. a clear
    // that meets a new event in the same cycle leaves the flag set, so an
    // event is never swallowed by a clear aimed at the one before it.

    // single-cycle apb: every access finishes in its first access cycle
    assign pready = 1'b1;
    assign addr_ok = (paddr == `TCC_OFF_FSEL) || (paddr == `TCC_OFF_FLAGS)
        || (paddr == `TCC_OFF_IEN) || (paddr == `TCC_OFF_GRA)
        || (paddr == `TCC_OFF_GRB) || (paddr == `TCC_OFF_MODE)
        || (paddr == `TCC_OFF_STAT);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && penable && !pwrite && addr_ok;

    // function codes; pwm combination mode on channels 3/4 forces plain compare
    always_comb
    begin
        code_a = tcc_pkg::func_code_t'(fsel_q[`TCC_AFIELD_LSB +: 3]);
        code_b = tcc_pkg::func_code_t'(fsel_q[`TCC_BFIELD_LSB +: 3]);
        if (pwm_combo_q && (CHANNEL >= 3))
        begin
            code_a = tcc_pkg::FN_CMP_NONE;
            code_b = tcc_pkg::FN_CMP_NONE;
        end
    end

    // pin inputs pass two flops before any logic reads them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a_q <= 2'b00;
            sync_b_q <= 2'b00;
            last_a_q <= 1'b0;
            last_b_q <= 1'b0;
        end
        else
        begin
            sync_a_q <= {sync_a_q[0], chan_pin_a_in};
            sync_b_q <= {sync_b_q[0], chan_pin_b_in};
            last_a_q <= sync_a_q[1];
            last_b_q <= sync_b_q[1];
        end
    end

    // edge detection runs on the second synchroniser flop and a copy of it
    // one cycle older; the first flop is never read by logic, so a level
    // that goes metastable there has a full cycle to settle.
    // reset clears both stages, so a pin that idles high shows one rising
    // edge right after reset; the function select is still at its reset
    // code (compare, no pin action) then, so that edge captures nothing.
    //
    // capture edge selection; code 111 never captures
    function automatic logic cap_hit(input tcc_pkg::func_code_t c, input logic now,
                                     input logic was);
        logic rise;
        logic fall;
        rise = now && !was;
        fall = !now && was;
        unique case (c)
            tcc_pkg::FN_CAP_RISE: cap_hit = rise;
            tcc_pkg::FN_CAP_FALL: cap_hit = fall;
            tcc_pkg::FN_CAP_BOTH: cap_hit = rise || fall;
            default: cap_hit = 1'b0;
        endcase
    endfunction

    assign cap_a = cap_hit(code_a, sync_a_q[1], last_a_q);
    assign cap_b = cap_hit(code_b, sync_b_q[1], last_b_q);
    // compare match counts once per counter tick, so a stalled counter does not re-fire
    assign cmp_a = !code_a[2] && count_tick && (timer_count == general_reg_a_q);
    assign cmp_b = !code_b[2] && count_tick && (timer_count == general_reg_b_q);
    // rollover going up, rollunder only while counting down
    assign wrap_evt = count_tick && (count_down ? (timer_count == {CW{1'b0}})
        : (timer_count == {CW{1'b1}}));
    assign set_evt = {wrap_evt, cmp_b || cap_b, cmp_a || cap_a};

    // general registers: software writes, captures latch the counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            general_reg_a_q <= {CW{1'b1}};
            general_reg_b_q <= {CW{1'b1}};
        end
        else
        begin
            if (cap_a)
                general_reg_a_q <= timer_count;
            else if (wr_en && paddr == `TCC_OFF_GRA)
                general_reg_a_q <= pwdata[CW-1:0];
            if (cap_b)
                general_reg_b_q <= timer_count;
            else if (wr_en && paddr == `TCC_OFF_GRB)
                general_reg_b_q <= pwdata[CW-1:0];
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fsel_q <= `TCC_FSEL_RESET;
            ien_q <= 3'b000;
            pwm_combo_q <= 1'b0;
        end
        else if (wr_en)
        begin
            if (paddr == `TCC_OFF_FSEL)
                fsel_q <= pwdata[7:0] | `TCC_FSEL_ONE_MASK;
            if (paddr == `TCC_OFF_IEN)
                ien_q <= pwdata[2:0];
            if (paddr == `TCC_OFF_MODE)
                pwm_combo_q <= pwdata[`TCC_MODE_PWM_BIT];
        end
    end

    // flag clearing works in two steps:
    // - a read of the flags register records which flags software saw set
    // - a later write of 0 to such a flag clears it, a write of 1 leaves it
    // the record of seen flags drops any flag that has been cleared since,
    // so a stale read cannot clear an event that arrives later.
    // a dma acknowledge clears the a flag directly, with no read before it,
    // on the channels that have a dma request path.
    //
    // flags: clear needs a prior read as 1; a same-cycle event wins over the clear
    always_comb
    begin
        clr_evt = 3'b000;
        if (wr_en && paddr == `TCC_OFF_FLAGS)
            clr_evt = flags_seen_q & ~pwdata[2:0];
        if (dma_ack_a && (CHANNEL < `TCC_NUM_DMA_CHANS))
            clr_evt[`TCC_BIT_MA] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_q <= 3'b000;
            flags_seen_q <= 3'b000;
        end
        else
        begin
            flags_q <= set_evt | (flags_q & ~clr_evt);
            if (rd_en && paddr == `TCC_OFF_FLAGS)
                flags_seen_q <= flags_q;
            else
                flags_seen_q <= flags_seen_q & flags_q & ~clr_evt;
        end
    end

    // compare outputs: the pin level only moves on a compare match of its
    // own register; a change of the function code alone never moves it.
    // both pins come out of reset low and stay low until the first match.
    // channel 2 has no toggle; a toggle code there drives the pin high.
    //
    // pin drive on compare match; level held in between
    function automatic logic pin_next(input tcc_pkg::func_code_t c, input logic cur);
        unique case (c)
            tcc_pkg::FN_CMP_LOW: pin_next = 1'b0;
            tcc_pkg::FN_CMP_HIGH: pin_next = 1'b1;
            tcc_pkg::FN_CMP_TOGGLE:
                pin_next = (CHANNEL == `TCC_NO_TOGGLE_CHAN) ? 1'b1 : !cur;
            default: pin_next = cur;
        endcase
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_pin_a_q <= 1'b0;
            chan_pin_b_q <= 1'b0;
        end
        else
        begin
            if (cmp_a)
                chan_pin_a_q <= pin_next(code_a, chan_pin_a_q);
            if (cmp_b)
                chan_pin_b_q <= pin_next(code_b, chan_pin_b_q);
        end
    end
    assign chan_pin_a = chan_pin_a_q;
    assign chan_pin_b = chan_pin_b_q;

    // interrupt requests are levels, live while flag and enable are both set
    assign match_a_irq = flags_q[`TCC_BIT_MA] && ien_q[`TCC_BIT_MA];
    assign match_b_irq = flags_q[`TCC_BIT_MB] && ien_q[`TCC_BIT_MB];
    assign wrap_irq = flags_q[`TCC_BIT_WRAP] && ien_q[`TCC_BIT_WRAP];

    // read path: the bus runs with no wait states, so read data must be
    // ready in the first access cycle; a plain mux of the registers does it.
    // reserved bits of the 8-bit registers read as 1, the undefined top
    // bit included except in function select, where bit 7 is writable and
    // resets to 1, so software that writes back what it read keeps the
    // reserved bits at 1 as required.
    // outside a read access the bus shows 0, so nothing leaks onto it.
    //
    // read data not registered; a plain mux presents it in the same access cycle
    always_comb
    begin
        prdata_q = 32'h0000_0000;
        unique case (paddr)
            `TCC_OFF_FSEL: prdata_q = {24'h00_0000, fsel_q};
            `TCC_OFF_FLAGS: prdata_q = {24'h00_0000, `TCC_FLAGS_RESET | {5'h00, flags_q}};
            `TCC_OFF_IEN: prdata_q = {24'h00_0000, `TCC_IEN_RESET | {5'h00, ien_q}};
            `TCC_OFF_GRA: prdata_q = {{(32-CW){1'b0}}, general_reg_a_q};
            `TCC_OFF_GRB: prdata_q = {{(32-CW){1'b0}}, general_reg_b_q};
            `TCC_OFF_MODE: prdata_q = {31'h0000_0000, pwm_combo_q};
            `TCC_OFF_STAT: prdata_q = {30'h0000_0000, chan_pin_b_q, chan_pin_a_q};
            default: prdata_q = 32'h0000_0000;
        endcase
    end
    assign prdata = rd_en ? prdata_q : 32'h0000_0000;
endmodule
`default_nettype wire
